// ### shared/cidt_defs.vh
// Constants for the instruction decode and cycle timing block
`ifndef CIDT_DEFS_VH
`define CIDT_DEFS_VH
`define CIDT_IW           14
`define CIDT_PH_LAST      2'h3
`define CIDT_PH_FIRST     2'h0
`define CIDT_PH_STEP      2'h1
`define CIDT_NOP          14'h0000
`define CIDT_FAM_BYTE     2'h0
`define CIDT_FAM_BIT      2'h1
`define CIDT_FAM_LIT      2'h2
`define CIDT_TOP2_BYTE    2'h0
`define CIDT_TOP2_BIT     2'h1
`define CIDT_TOP6_MISC    6'h00
`define CIDT_TOP6_DECSKP  6'h0b
`define CIDT_TOP6_INCSKP  6'h0f
`define CIDT_TOP6_EXITLIT 6'h34
`define CIDT_TOP5_RELJMP  5'h19
`define CIDT_TOP3_CALL    3'h4
`define CIDT_TOP3_ABSJMP  3'h5
`define CIDT_BITOP_CLR    4'h4
`define CIDT_BITOP_SET    4'h5
`define CIDT_BITOP_SKCLR  4'h6
`define CIDT_BITOP_SKSET  4'h7
`define CIDT_LOW7_RETURN  7'h08
`define CIDT_LOW7_INTEXIT 7'h09
`define CIDT_LOW7_CALLACC 7'h0a
`define CIDT_LOW7_ACCJMP  7'h0b
`define CIDT_IND_REG0     7'h00
`define CIDT_IND_REG1     7'h01
`define CIDT_FADDR_MAX    7'h7f
`define CIDT_BIT_CNT      32'h8
`define CIDT_F_TOP6       13:8
`define CIDT_F_TOP5       13:9
`define CIDT_F_TOP4       13:10
`define CIDT_F_TOP3       13:11
`define CIDT_F_TOP2       13:12
`define CIDT_F_BSEL       9:7
`define CIDT_F_FADDR      6:0
`define CIDT_F_DEST       7
`define CIDT_F_PTR        0
`endif

// ### design/cidt_phase_gen.v
// Four-phase instruction cycle sequencer
`timescale 1ns/10ps
`include "cidt_defs.vh"
module cidt_phase_gen
(
  input  wire       sys_clk,
  input  wire       arst_n,
  output reg  [1:0] phase_ff,
  output reg        cyc_end_ff
);
  wire [1:0] nxt_phase;

  assign nxt_phase = phase_ff + `CIDT_PH_STEP;

  always @(posedge sys_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      phase_ff   <= `CIDT_PH_FIRST;
      cyc_end_ff <= 1'b0;
    end
    else
    begin
      phase_ff   <= nxt_phase;
      // High during the last of the four clocks
      cyc_end_ff <= (nxt_phase == `CIDT_PH_LAST);
    end
  end
endmodule

// ### design/cidt_decoder.v
// Instruction decoder and instruction cycle timing
//
// Behaviour
// - One 14-bit word holds opcode and operands
// - Sort opcodes into byte, bit, literal/control
// - Single cycle unless a listed exception
// - Both call forms take two cycles
// - All three return forms take two cycles
// - Jumps and taken skips take two cycles
// - Indirect access to program memory adds one
// - Instruction cycle is four clock periods
// - File operand always read; stored only for file-destination byte ops and bit clear/set
// - Destination bit zero accumulator, one file
// - File address spans 0x00 to 0x7F
// - Bit operand picks one of eight bits
// - Pointer number selects pointer zero or one
// - Don't-care word bits ignored by decode
`timescale 1ns/10ps
`include "cidt_defs.vh"
module cidt_decoder
(
  input  wire                   sys_clk,
  input  wire                   arst_n,
  input  wire [`CIDT_IW-1:0]    instr_word,
  input  wire                   skip_hit,
  input  wire                   fp0_in_pm,
  input  wire                   fp1_in_pm,
  output wire [1:0]             cyc_phase,
  output wire                   cyc_end,
  output reg                    word_take_ff,
  output reg                    exec_valid_ff,
  output reg                    idle_cycle_ff,
  output reg                    extra_cycle_ff,
  output reg  [1:0]             op_family_ff,
  output reg                    file_rd_ff,
  output reg                    file_wr_ff,
  output reg                    acc_wr_ff,
  output reg  [6:0]             reg_addr_ff,
  output reg  [7:0]             bit_mask_ff,
  output reg                    ptr_num_ff,
  output reg                    ind_access_ff,
  output reg                    flow_change_ff
);
  localparam [2:0] ST_EXEC = 3'b001;
  localparam [2:0] ST_XTRA = 3'b010;
  localparam [2:0] ST_IDLE = 3'b100;

  reg  [`CIDT_IW-1:0] ir_ff;
  reg  [2:0]          state_ff;
  reg  [2:0]          nxt_state;
  reg                 nxt_take;

  // Opcode and operand fields of the held word
  wire [5:0] top6     = ir_ff[`CIDT_F_TOP6];
  wire [4:0] top5     = ir_ff[`CIDT_F_TOP5];
  wire [3:0] top4     = ir_ff[`CIDT_F_TOP4];
  wire [2:0] top3     = ir_ff[`CIDT_F_TOP3];
  wire [1:0] top2     = ir_ff[`CIDT_F_TOP2];
  wire [6:0] faddr    = ir_ff[`CIDT_F_FADDR];
  wire [2:0] bsel     = ir_ff[`CIDT_F_BSEL];
  wire       dest_sel = ir_ff[`CIDT_F_DEST];
  wire       ptr_sel  = faddr[`CIDT_F_PTR];

  // Four clocks per instruction cycle
  cidt_phase_gen u_phase
  (
    .sys_clk    (sys_clk),
    .arst_n     (arst_n),
    .phase_ff   (cyc_phase),
    .cyc_end_ff (cyc_end)
  );

  // Family sort; misc control words live under byte prefix
  wire is_misc   = (top6 == `CIDT_TOP6_MISC) && !dest_sel;
  wire is_byte   = (top2 == `CIDT_TOP2_BYTE) && !is_misc;
  wire is_bit    = (top2 == `CIDT_TOP2_BIT);
  wire [1:0] fam = is_byte ? `CIDT_FAM_BYTE :
                   is_bit  ? `CIDT_FAM_BIT  : `CIDT_FAM_LIT;

  // Only significant bits compared; operand bits are don't care
  wire op_call    = (top3 == `CIDT_TOP3_CALL);
  wire op_callacc = is_misc && (faddr == `CIDT_LOW7_CALLACC);
  wire op_ret     = is_misc && (faddr == `CIDT_LOW7_RETURN);
  wire op_intexit = is_misc && (faddr == `CIDT_LOW7_INTEXIT);
  wire op_exitlit = (top6 == `CIDT_TOP6_EXITLIT);
  wire op_absjmp  = (top3 == `CIDT_TOP3_ABSJMP);
  wire op_reljmp  = (top5 == `CIDT_TOP5_RELJMP);
  wire op_accjmp  = is_misc && (faddr == `CIDT_LOW7_ACCJMP);
  wire op_skip    = (top4 == `CIDT_BITOP_SKCLR) ||
                    (top4 == `CIDT_BITOP_SKSET) ||
                    (top6 == `CIDT_TOP6_DECSKP) ||
                    (top6 == `CIDT_TOP6_INCSKP);
  wire bit_write  = (top4 == `CIDT_BITOP_CLR) || (top4 == `CIDT_BITOP_SET);

  // Skip counts as two cycles only once its test hits
  wire call_two = op_call || op_callacc;
  wire ret_two  = op_ret || op_exitlit || op_intexit;
  wire jmp_two  = op_absjmp || op_reljmp || op_accjmp;
  wire skip_two = op_skip && skip_hit;
  wire two_cyc  = call_two || ret_two || jmp_two || skip_two;

  // File operand present for byte and bit families
  wire file_ref = is_byte || is_bit;
  wire ind_ref  = file_ref && ((faddr == `CIDT_IND_REG0) ||
                               (faddr == `CIDT_IND_REG1));
  // Pointer bit of the address picks the pointer under test
  wire ind_pm   = ind_ref && (ptr_sel ? fp1_in_pm : fp0_in_pm);

  // Cycle sequencing at each instruction cycle boundary
  always @*
  begin
    nxt_state = state_ff;
    nxt_take  = 1'b0;
    if (cyc_end)
    begin
      case (state_ff)
        ST_EXEC:
        begin
          if (ind_pm)
            nxt_state = ST_XTRA;
          else if (two_cyc)
            nxt_state = ST_IDLE;
          else
            nxt_take  = 1'b1;
        end
        ST_XTRA:
        begin
          // Skip test sampled again; flush follows the extra cycle
          if (two_cyc)
            nxt_state = ST_IDLE;
          else
          begin
            nxt_state = ST_EXEC;
            nxt_take  = 1'b1;
          end
        end
        ST_IDLE:
        begin
          // Word fetched during the flow change never executes
          nxt_state = ST_EXEC;
          nxt_take  = 1'b1;
        end
        default:
        begin
          nxt_state = ST_EXEC;
          nxt_take  = 1'b1;
        end
      endcase
    end
  end

  always @(posedge sys_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      state_ff     <= ST_EXEC;
      ir_ff        <= `CIDT_NOP;
      word_take_ff <= 1'b0;
    end
    else
    begin
      state_ff     <= nxt_state;
      word_take_ff <= nxt_take;
      // Word fetched during a flow change is dropped
      if (nxt_take)
        ir_ff <= instr_word;
    end
  end

  // Per-bit target select for bit operations
  wire [7:0] nxt_mask;
  genvar gi;
  generate
    for (gi = 0; gi < `CIDT_BIT_CNT; gi = gi + 1)
    begin : g_mask
      assign nxt_mask[gi] = is_bit && (bsel == gi);
    end
  endgenerate

  // Execute qualifiers only in the held word's own cycle
  wire run = (state_ff == ST_EXEC);

  always @(posedge sys_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      exec_valid_ff  <= 1'b0;
      idle_cycle_ff  <= 1'b0;
      extra_cycle_ff <= 1'b0;
      op_family_ff   <= `CIDT_FAM_LIT;
      file_rd_ff     <= 1'b0;
      file_wr_ff     <= 1'b0;
      acc_wr_ff      <= 1'b0;
      reg_addr_ff    <= `CIDT_IND_REG0;
      bit_mask_ff    <= 8'h00;
      ptr_num_ff     <= 1'b0;
      ind_access_ff  <= 1'b0;
      flow_change_ff <= 1'b0;
    end
    else
    begin
      exec_valid_ff  <= run;
      idle_cycle_ff  <= (state_ff == ST_IDLE);
      extra_cycle_ff <= (state_ff == ST_XTRA);
      op_family_ff   <= fam;
      // Read issued for every file operand, even write-only
      file_rd_ff     <= run && file_ref;
      // Destination select: 1 back to file, 0 to accumulator
      file_wr_ff     <= run && ((is_byte && dest_sel) ||
                                (is_bit && bit_write));
      acc_wr_ff      <= run && is_byte && !dest_sel;
      // Operand fields follow the held word, idle cycles included
      reg_addr_ff    <= faddr & `CIDT_FADDR_MAX;
      bit_mask_ff    <= nxt_mask;
      ptr_num_ff     <= ptr_sel;
      ind_access_ff  <= ind_ref;
      flow_change_ff <= run && two_cyc;
    end
  end
endmodule

// ### verification/cidt_props.sv
// Port assertions for the decoder
`timescale 1ns/10ps
module cidt_props
(
  input wire       sys_clk,
  input wire       arst_n,
  input wire [1:0] cyc_phase,
  input wire       cyc_end,
  input wire       word_take_ff,
  input wire       idle_cycle_ff,
  input wire       extra_cycle_ff,
  input wire [1:0] op_family_ff,
  input wire [7:0] bit_mask_ff,
  input wire       file_rd_ff,
  input wire       file_wr_ff,
  input wire       acc_wr_ff
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!arst_n);
  phase_step_a: assert property (
    1'b1 |=> (cyc_phase - $past(cyc_phase)) == 2'h1) else $error("phase");
  cycle_end_a: assert property (
    cyc_end == (cyc_phase == 2'h3)) else $error("cycle end");
  take_phase_a: assert property (
    word_take_ff |-> cyc_phase == 2'h0) else $error("take phase");
  take_gap_a: assert property (
    word_take_ff |=> !word_take_ff [*3]) else $error("take gap");
  idle_len_a: assert property (
    $rose(idle_cycle_ff) |-> idle_cycle_ff [*4] ##1 !idle_cycle_ff)
    else $error("idle length");
  extra_len_a: assert property (
    $rose(extra_cycle_ff) |-> extra_cycle_ff [*4] ##1 !extra_cycle_ff)
    else $error("extra length");
  bit_mask_a: assert property (
    op_family_ff == 2'h1 ? $onehot(bit_mask_ff) : bit_mask_ff == 8'h00)
    else $error("bit mask");
  dest_excl_a: assert property (
    !(file_wr_ff && acc_wr_ff)) else $error("two destinations");
  rmw_read_a: assert property (
    file_wr_ff |-> file_rd_ff) else $error("write without read");
endmodule
bind cidt_decoder cidt_props i_cidt_props
(
  .sys_clk(sys_clk), .arst_n(arst_n), .cyc_phase(cyc_phase),
  .cyc_end(cyc_end),
  .word_take_ff(word_take_ff), .idle_cycle_ff(idle_cycle_ff),
  .extra_cycle_ff(extra_cycle_ff), .op_family_ff(op_family_ff),
  .bit_mask_ff(bit_mask_ff), .file_rd_ff(file_rd_ff),
  .file_wr_ff(file_wr_ff), .acc_wr_ff(acc_wr_ff)
);

// ### verification/cidt_mem_model.sv
// Program memory model, one word per fetch
`timescale 1ns/10ps
module cidt_mem_model
(
  input  wire        sys_clk,
  input  wire        arst_n,
  input  wire        word_take_ff,
  output wire [13:0] instr_word
);
  reg [13:0] mem [0:63];
  reg [5:0]  pc_ff;
  integer    i;
  initial
  begin
    for (i = 0; i < 64; i = i + 1)
      mem[i] = 14'h0000;
  end
  always @(posedge sys_clk or negedge arst_n)
  begin
    if (!arst_n)
      pc_ff <= 6'h00;
    else if (word_take_ff)
      pc_ff <= pc_ff + 6'h01;
  end
  assign instr_word = mem[pc_ff];
endmodule

// ### verification/cpu_instruction_decode_timing_test.sv
// Self-checking bench for decode and cycle timing
`timescale 1ns/10ps
module cpu_instruction_decode_timing_test;
  reg         sys_clk = 1'b0;
  reg         arst_n = 1'b0;
  reg         skip_hit = 1'b0;
  reg         fp0_in_pm = 1'b0;
  reg         fp1_in_pm = 1'b0;
  wire [13:0] instr_word;
  wire [1:0]  op_family_ff;
  wire [6:0]  reg_addr_ff;
  wire [7:0]  bit_mask_ff;
  wire        word_take_ff, exec_valid_ff, ind_access_ff;
  wire        file_rd_ff, file_wr_ff, acc_wr_ff;
  wire        ptr_num_ff, flow_change_ff;
  integer     error_cnt = 0, compares = 0, k = 1;
  always #50 sys_clk = ~sys_clk;
  cidt_mem_model i_cidt_mem_model
  (
    .sys_clk(sys_clk), .arst_n(arst_n), .word_take_ff(word_take_ff),
    .instr_word(instr_word)
  );
  cidt_decoder i_cidt_decoder
  (
    .sys_clk(sys_clk), .arst_n(arst_n), .instr_word(instr_word),
    .skip_hit(skip_hit), .fp0_in_pm(fp0_in_pm), .fp1_in_pm(fp1_in_pm),
    .cyc_phase(), .cyc_end(), .word_take_ff(word_take_ff),
    .exec_valid_ff(exec_valid_ff), .idle_cycle_ff(), .extra_cycle_ff(),
    .op_family_ff(op_family_ff), .file_rd_ff(file_rd_ff),
    .file_wr_ff(file_wr_ff), .acc_wr_ff(acc_wr_ff),
    .ptr_num_ff(ptr_num_ff),
    .reg_addr_ff(reg_addr_ff), .bit_mask_ff(bit_mask_ff),
    .ind_access_ff(ind_access_ff), .flow_change_ff(flow_change_ff)
  );
  task chk(input string nm, input [7:0] exp, input [7:0] got);
  begin
    compares = compares + 1;
    if (got !== exp)
    begin
      error_cnt = error_cnt + 1;
      $display("ERROR %s expected %h seen %h", nm, exp, got);
    end
  end
  endtask
  // f: {fp1, fp0, skip, family[1:0], read, write, acc}
  task step(input [13:0] w, input [3:0] n, input [7:0] f);
    integer c;
    reg     xtra;
  begin
    // Next slot stays a nop, taken when this word ends
    i_cidt_mem_model.mem[k] = w;
    k = k + 2;
    xtra = f[2] && (w[6:1] == 6'h00) && (w[0] ? f[7] : f[6]);
    c = 0;
    @(negedge sys_clk);
    while (word_take_ff !== 1'b1 && c < 20)
    begin
      @(negedge sys_clk);
      c = c + 1;
    end
    @(posedge sys_clk);
    {fp1_in_pm, fp0_in_pm, skip_hit} <= f[7:5];
    @(negedge sys_clk);
    chk("family", f[4:3], op_family_ff);
    chk("access", f[2:0], {file_rd_ff, file_wr_ff, acc_wr_ff});
    chk("exec", 8'h01, exec_valid_ff);
    chk("mask", f[4:3] == 2'h1 ? 8'h01 << w[9:7] : 8'h00,
        bit_mask_ff);
    if (f[2])
    begin
      chk("addr", w[6:0], reg_addr_ff);
      chk("indirect", w[6:1] == 6'h00, ind_access_ff);
      chk("pointer", w[0], ptr_num_ff);
    end
    @(negedge sys_clk);
    chk("flow", n == (xtra ? 4'hc : 4'h8), flow_change_ff);
    c = 2;
    while (word_take_ff !== 1'b1 && c < 20)
    begin
      @(negedge sys_clk);
      c = c + 1;
      if (c == 6)
        chk("flush", 8'h00, exec_valid_ff);
    end
    chk("clocks", n, c[7:0]);
  end
  endtask
  task t_byte;
  begin
    step(14'h0725, 4'h4, 8'h05);
    step(14'h07ff, 4'h4, 8'h06);
  end
  endtask
  task t_bit;
  begin
    step(14'h1790, 4'h4, 8'h0e);
    step(14'h1010, 4'h4, 8'h0e);
    step(14'h1c10, 4'h8, 8'h2c);
    step(14'h1810, 4'h4, 8'h0c);
  end
  endtask
  task t_flow;
  begin
    step(14'h2123, 4'h8, 8'h10);
    step(14'h000a, 4'h8, 8'h10);
    step(14'h0008, 4'h8, 8'h10);
    step(14'h0009, 4'h8, 8'h10);
    step(14'h3455, 4'h8, 8'h10);
    step(14'h2800, 4'h8, 8'h10);
    step(14'h3205, 4'h8, 8'h10);
    step(14'h000b, 4'h8, 8'h10);
    step(14'h0b90, 4'h8, 8'h26);
    step(14'h0f90, 4'h8, 8'h26);
    step(14'h0b90, 4'h4, 8'h06);
  end
  endtask
  task t_ind;
  begin
    step(14'h0781, 4'h8, 8'h86);
    step(14'h0781, 4'h4, 8'h46);
    step(14'h0780, 4'h8, 8'h46);
    step(14'h0b81, 4'hc, 8'ha6);
    step(14'h0060, 4'h4, 8'h10);
  end
  endtask
  task tally_and_finish;
  begin
    $display("compares %0d errors %0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  end
  endtask
  initial
  begin
    repeat (6) @(posedge sys_clk);
    arst_n <= 1'b1;
    @(negedge sys_clk);
    while (word_take_ff !== 1'b1)
      @(negedge sys_clk);
    t_byte;
    t_bit;
    t_flow;
    t_ind;
    tally_and_finish;
  end
  initial
  begin
    #100000;
    error_cnt = error_cnt + 1;
    tally_and_finish;
  end
endmodule
